// >>> logic/cpu_core_register_set.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 8-bit main operand register at FE00H, cleared to 00H on reset.
// - second and main registers form one 16-bit operand and result for word math.
// - multiply and divide results load main, second and third registers together.
// - second register drives upper 8 bits of the 24-bit external address.
// - second register is 8 bits, read/write at FE01H, reset to zero.
// - third register at FE02H, reset clear, signed offset added to pointer.
// - status word at FE06H, reset clear, bit layout carry down to parity.
// - carry set by add or rotate carry, subtract or compare borrow, else cleared.
// - half carry from bit 3, or upper-byte bit 3 in word math.
// - status bits 5 and 4 change only by direct writes.
// - bank bit selects lower or upper ROM half for table reads.
// - overflow set when signed add or subtract gives an inconsistent sign.
// - overflow set when upper product bits of a multiply are nonzero.
// - divide by zero sets overflow.
// - status bit 1 holds the ninth RAM data bit.
// - parity bit always shows odd count of ones in the main register.
// - 16-bit stack pointer, low FE0A, high FE0B, reset 0000H.
// - pointer increments before each stack store, decrements after each read.
// - call pushes bank+low then high; return pops high then bank+low.
// - 64 two-byte pointers occupy RAM 0 to 7FH, still ordinary RAM.
// - pointer low byte at even address, high byte at next odd address.
module cpu_core_register_set
   import ccr_pkg::*;
#(
   parameter int unsigned PTR_COUNT = CCR_PTR_COUNT
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [15:0] busAddr,
   input wire logic busWe,
   input wire logic busRe,
   input wire logic [7:0] busWdata,
   output logic [7:0] busRdata,
   input wire logic ldA,
   input wire logic ldB,
   input wire logic ldC,
   input wire logic [7:0] ldData,
   input wire logic aluGo,
   input wire ccr_op_t aluOp,
   input wire logic aluWide,
   input wire logic aluUseCarry,
   input wire logic [15:0] aluOperand,
   input wire logic [23:0] mdResult,
   input wire logic [15:0] mdHigh,
   input wire logic [15:0] divisor,
   input wire logic ninthLoad,
   input wire logic ninthIn,
   input wire logic [15:0] ptrBase,
   input wire logic [5:0] ptrIndex,
   input wire logic [16:0] tblPtr,
   input wire logic callReq,
   input wire logic [16:0] callAddr,
   input wire logic callBank,
   input wire logic retReq,
   input wire logic pushReq,
   input wire logic [8:0] pushData,
   input wire logic popReq,
   input wire logic [8:0] stkRdData,
   output logic [7:0] mainOperand,
   output logic [7:0] secondOperand,
   output logic [7:0] thirdOperand,
   output logic [7:0] statusWord,
   output logic [15:0] stackPointer,
   output logic [7:0] extAddrHigh,
   output logic [15:0] offsetAddr,
   output logic [17:0] romAddr,
   output logic [15:0] ptrAddrLo,
   output logic [15:0] ptrAddrHi,
   output logic stkWe,
   output logic stkRe,
   output logic [15:0] stkAddr,
   output logic [8:0] stkWrData,
   output logic [16:0] retAddr,
   output logic retBank,
   output logic retDone
);
   if (PTR_COUNT < 1 || PTR_COUNT > CCR_PTR_COUNT) begin : gBadPtrCount
      $error("PTR_COUNT must lie between 1 and 64");
   end

   ccr_alu_if aluBus ();

   logic [7:0] aReg_r, aNxt;
   logic [7:0] second_operand_reg_r, bNxt;
   logic [7:0] third_operand_reg_r, cNxt;
   logic [7:0] psw_r, pswNxt;
   logic [15:0] sp_r, spNxt;
   logic [7:0] busRdata_r, busRdataNxt;
   logic [7:0] extHi_r, extHiNxt;
   logic [15:0] offAddr_r, offAddrNxt;
   logic [17:0] romAddr_r, romAddrNxt;
   logic [15:0] ptrLo_r, ptrLoNxt;
   logic [15:0] ptrHi_r, ptrHiNxt;
   ccr_state_t st_r, stNxt;
   logic stkWe_r, stkWeNxt;
   logic stkRe_r, stkReNxt;
   logic [15:0] stkAddr_r, stkAddrNxt;
   logic [8:0] stkWrData_r, stkWrDataNxt;
   logic [8:0] hold_r, holdNxt;
   logic [16:0] retAddr_r, retAddrNxt;
   logic retBank_r, retBankNxt;
   logic retDone_r, retDoneNxt;
   logic spInc;
   logic spDec;

   assign aluBus.op = aluGo ? aluOp : CCR_OP_NONE;
   assign aluBus.wide = aluWide;
   // byte math sees a clean upper byte, so carry and borrow come from bit 7
   assign aluBus.opA = aluWide ? {second_operand_reg_r, aReg_r} : {8'h00, aReg_r};
   assign aluBus.opB = aluWide ? aluOperand : {8'h00, aluOperand[7:0]};
   assign aluBus.cin = aluUseCarry & psw_r[CCR_BIT_CY];
   assign aluBus.mdHi = mdHigh;
   assign aluBus.divisor = divisor;

   ccr_flag_unit uFlags (
      .alu(aluBus)
   );

   // stack sequencing: call and return take two slots each
   always_comb begin
      stNxt = st_r;
      spInc = 1'b0;
      spDec = 1'b0;
      stkWeNxt = 1'b0;
      stkReNxt = 1'b0;
      stkAddrNxt = stkAddr_r;
      stkWrDataNxt = stkWrData_r;
      holdNxt = hold_r;
      retAddrNxt = retAddr_r;
      retBankNxt = retBank_r;
      retDoneNxt = 1'b0;
      case (st_r)
         CCR_ST_IDLE: begin
            if (callReq) begin
               spInc = 1'b1;
               stkWeNxt = 1'b1;
               stkAddrNxt = sp_r + CCR_SP_STEP;
               stkWrDataNxt = {callBank, callAddr[7:0]};
               holdNxt = callAddr[16:8];
               stNxt = CCR_ST_CALL_HI;
            end else if (retReq) begin
               stkReNxt = 1'b1;
               stkAddrNxt = sp_r;
               spDec = 1'b1;
               stNxt = CCR_ST_RET_LO;
            end else if (pushReq) begin
               spInc = 1'b1;
               stkWeNxt = 1'b1;
               stkAddrNxt = sp_r + CCR_SP_STEP;
               stkWrDataNxt = pushData;
            end else if (popReq) begin
               stkReNxt = 1'b1;
               stkAddrNxt = sp_r;
               spDec = 1'b1;
            end
         end
         CCR_ST_CALL_HI: begin
            spInc = 1'b1;
            stkWeNxt = 1'b1;
            stkAddrNxt = sp_r + CCR_SP_STEP;
            stkWrDataNxt = hold_r;
            stNxt = CCR_ST_IDLE;
         end
         CCR_ST_RET_LO: begin
            stkReNxt = 1'b1;
            stkAddrNxt = sp_r;
            spDec = 1'b1;
            stNxt = CCR_ST_RET_CAP_HI;
         end
         CCR_ST_RET_CAP_HI: begin
            // RAM answers one cycle after the read strobe
            holdNxt = stkRdData;
            stNxt = CCR_ST_RET_CAP_LO;
         end
         CCR_ST_RET_CAP_LO: begin
            retAddrNxt = {hold_r, stkRdData[7:0]};
            retBankNxt = stkRdData[8];
            retDoneNxt = 1'b1;
            stNxt = CCR_ST_IDLE;
         end
         default: begin
            stNxt = CCR_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= CCR_ST_IDLE;
         stkWe_r <= 1'b0;
         stkRe_r <= 1'b0;
         stkAddr_r <= CCR_RST_SP;
         stkWrData_r <= 9'h000;
         hold_r <= 9'h000;
         retAddr_r <= 17'h00000;
         retBank_r <= 1'b0;
         retDone_r <= 1'b0;
      end else begin
         st_r <= stNxt;
         stkWe_r <= stkWeNxt;
         stkRe_r <= stkReNxt;
         stkAddr_r <= stkAddrNxt;
         stkWrData_r <= stkWrDataNxt;
         hold_r <= holdNxt;
         retAddr_r <= retAddrNxt;
         retBank_r <= retBankNxt;
         retDone_r <= retDoneNxt;
      end
   end

   // register set: datapath loads, then flags, then direct writes on top, parity last
   always_comb begin
      aNxt = aReg_r;
      bNxt = second_operand_reg_r;
      cNxt = third_operand_reg_r;
      pswNxt = psw_r;
      spNxt = sp_r;
      busRdataNxt = busRdata_r;
      if (ldA) begin
         aNxt = ldData;
      end
      if (ldB) begin
         bNxt = ldData;
      end
      if (ldC) begin
         cNxt = ldData;
      end
      if (aluBus.resUpd) begin
         aNxt = aluBus.result[7:0];
         if (aluWide) begin
            bNxt = aluBus.result[15:8];
         end
      end
      if (aluGo && (aluOp == CCR_OP_MUL16 || aluOp == CCR_OP_MUL24 || aluOp == CCR_OP_DIV)) begin
         {cNxt, bNxt, aNxt} = mdResult;
      end
      // user bits and bank bit are never touched here
      if (aluBus.cyUpd) begin
         pswNxt[CCR_BIT_CY] = aluBus.cy;
      end
      if (aluBus.acUpd) begin
         pswNxt[CCR_BIT_AC] = aluBus.ac;
      end
      if (aluBus.ovUpd) begin
         pswNxt[CCR_BIT_OV] = aluBus.ov;
      end
      if (ninthLoad) begin
         pswNxt[CCR_BIT_NINTH] = ninthIn;
      end
      if (spInc) begin
         spNxt = sp_r + CCR_SP_STEP;
      end else if (spDec) begin
         spNxt = sp_r - CCR_SP_STEP;
      end
      if (busWe) begin
         case (busAddr)
            CCR_ADDR_MAIN: aNxt = busWdata;
            CCR_ADDR_SECOND: bNxt = busWdata;
            CCR_ADDR_THIRD: cNxt = busWdata;
            CCR_ADDR_STATUS: pswNxt = busWdata;
            CCR_ADDR_SP_LO: spNxt[7:0] = busWdata;
            CCR_ADDR_SP_HI: spNxt[15:8] = busWdata;
            default: begin
            end
         endcase
      end
      pswNxt[CCR_BIT_PAR] = ^aNxt;
      if (busRe) begin
         case (busAddr)
            CCR_ADDR_MAIN: busRdataNxt = aReg_r;
            CCR_ADDR_SECOND: busRdataNxt = second_operand_reg_r;
            CCR_ADDR_THIRD: busRdataNxt = third_operand_reg_r;
            CCR_ADDR_STATUS: busRdataNxt = psw_r;
            CCR_ADDR_SP_LO: busRdataNxt = sp_r[7:0];
            CCR_ADDR_SP_HI: busRdataNxt = sp_r[15:8];
            default: busRdataNxt = CCR_RD_UNMAPPED;
         endcase
      end
      extHiNxt = bNxt;
      offAddrNxt = ptrBase + {{8{third_operand_reg_r[7]}}, third_operand_reg_r};
      romAddrNxt = {pswNxt[CCR_BIT_BANK], tblPtr};
      // index picks an even-aligned pair, high byte right after
      ptrLoNxt = CCR_PTR_BASE + {9'h000, ptrIndex, 1'b0};
      ptrHiNxt = ptrLoNxt + CCR_PTR_HI_OFS;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         aReg_r <= CCR_RST_BYTE;
         second_operand_reg_r <= CCR_RST_BYTE;
         third_operand_reg_r <= CCR_RST_BYTE;
         psw_r <= CCR_RST_BYTE;
         sp_r <= CCR_RST_SP;
         busRdata_r <= CCR_RST_BYTE;
         extHi_r <= CCR_RST_BYTE;
         offAddr_r <= CCR_RST_SP;
         romAddr_r <= 18'h00000;
         ptrLo_r <= CCR_PTR_BASE;
         ptrHi_r <= CCR_PTR_BASE;
      end else begin
         aReg_r <= aNxt;
         second_operand_reg_r <= bNxt;
         third_operand_reg_r <= cNxt;
         psw_r <= pswNxt;
         sp_r <= spNxt;
         busRdata_r <= busRdataNxt;
         extHi_r <= extHiNxt;
         offAddr_r <= offAddrNxt;
         romAddr_r <= romAddrNxt;
         ptrLo_r <= ptrLoNxt;
         ptrHi_r <= ptrHiNxt;
      end
   end

   assign busRdata = busRdata_r;
   assign mainOperand = aReg_r;
   assign secondOperand = second_operand_reg_r;
   assign thirdOperand = third_operand_reg_r;
   assign statusWord = psw_r;
   assign stackPointer = sp_r;
   assign extAddrHigh = extHi_r;
   assign offsetAddr = offAddr_r;
   assign romAddr = romAddr_r;
   assign ptrAddrLo = ptrLo_r;
   assign ptrAddrHi = ptrHi_r;
   assign stkWe = stkWe_r;
   assign stkRe = stkRe_r;
   assign stkAddr = stkAddr_r;
   assign stkWrData = stkWrData_r;
   assign retAddr = retAddr_r;
   assign retBank = retBank_r;
   assign retDone = retDone_r;
endmodule
`default_nettype wire

// >>> shared/ccr_pkg.sv
package ccr_pkg;
   // data addresses of the register set
   localparam logic [15:0] CCR_ADDR_MAIN = 16'hFE00;
   localparam logic [15:0] CCR_ADDR_SECOND = 16'hFE01;
   localparam logic [15:0] CCR_ADDR_THIRD = 16'hFE02;
   localparam logic [15:0] CCR_ADDR_STATUS = 16'hFE06;
   localparam logic [15:0] CCR_ADDR_SP_LO = 16'hFE0A;
   localparam logic [15:0] CCR_ADDR_SP_HI = 16'hFE0B;
   // reset values and unmapped read value
   localparam logic [7:0] CCR_RST_BYTE = 8'h00;
   localparam logic [15:0] CCR_RST_SP = 16'h0000;
   localparam logic [7:0] CCR_RD_UNMAPPED = 8'h00;
   // status word fields
   localparam int unsigned CCR_BIT_CY = 7;
   localparam int unsigned CCR_BIT_AC = 6;
   localparam int unsigned CCR_BIT_USER_HI = 5;
   localparam int unsigned CCR_BIT_USER_LO = 4;
   localparam int unsigned CCR_BIT_BANK = 3;
   localparam int unsigned CCR_BIT_OV = 2;
   localparam int unsigned CCR_BIT_NINTH = 1;
   localparam int unsigned CCR_BIT_PAR = 0;
   // carry positions: byte result, word result, nibble and upper-byte nibble
   localparam int unsigned CCR_CY_POS_8 = 8;
   localparam int unsigned CCR_CY_POS_16 = 16;
   localparam int unsigned CCR_AC_POS_8 = 4;
   localparam int unsigned CCR_AC_POS_16 = 12;
   // stack and pointer area
   localparam logic [15:0] CCR_SP_STEP = 16'h0001;
   localparam logic [15:0] CCR_PTR_BASE = 16'h0000;
   localparam logic [15:0] CCR_PTR_HI_OFS = 16'h0001;
   localparam int unsigned CCR_PTR_COUNT = 64;

   typedef enum logic [2:0] {
      CCR_OP_NONE = 3'h0,
      CCR_OP_ADD = 3'h1,
      CCR_OP_SUB = 3'h2,
      CCR_OP_CMP = 3'h3,
      CCR_OP_ROT = 3'h4,
      CCR_OP_MUL16 = 3'h5,
      CCR_OP_MUL24 = 3'h6,
      CCR_OP_DIV = 3'h7
   } ccr_op_t;

   typedef enum logic [4:0] {
      CCR_ST_IDLE = 5'b00001,
      CCR_ST_CALL_HI = 5'b00010,
      CCR_ST_RET_LO = 5'b00100,
      CCR_ST_RET_CAP_HI = 5'b01000,
      CCR_ST_RET_CAP_LO = 5'b10000
   } ccr_state_t;
endpackage

// >>> shared/ccr_alu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ccr_alu_if;
   import ccr_pkg::*;
   ccr_op_t op;
   logic wide;
   logic [15:0] opA;
   logic [15:0] opB;
   logic cin;
   logic [15:0] mdHi;
   logic [15:0] divisor;
   logic [15:0] result;
   logic cy;
   logic ac;
   logic ov;
   logic cyUpd;
   logic acUpd;
   logic ovUpd;
   logic resUpd;
   modport regs (output op, wide, opA, opB, cin, mdHi, divisor,
      input result, cy, ac, ov, cyUpd, acUpd, ovUpd, resUpd);
   modport alu (input op, wide, opA, opB, cin, mdHi, divisor,
      output result, cy, ac, ov, cyUpd, acUpd, ovUpd, resUpd);
endinterface
`default_nettype wire

// >>> logic/ccr_flag_unit.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_flag_unit
   import ccr_pkg::*;
(
   ccr_alu_if.alu alu
);
   logic [16:0] full;
   logic [12:0] nib16;
   logic [4:0] nib8;
   logic signA;
   logic signB;
   logic signR;

   always_comb begin
      full = 17'h00000;
      nib16 = 13'h0000;
      nib8 = 5'h00;
      alu.result = alu.opA;
      alu.cy = 1'b0;
      alu.ac = 1'b0;
      alu.ov = 1'b0;
      alu.cyUpd = 1'b0;
      alu.acUpd = 1'b0;
      alu.ovUpd = 1'b0;
      alu.resUpd = 1'b0;
      case (alu.op)
         CCR_OP_ADD: begin
            full = {1'b0, alu.opA} + {1'b0, alu.opB} + {16'h0000, alu.cin};
            nib16 = {1'b0, alu.opA[11:0]} + {1'b0, alu.opB[11:0]} + {12'h000, alu.cin};
            nib8 = {1'b0, alu.opA[3:0]} + {1'b0, alu.opB[3:0]} + {4'h0, alu.cin};
         end
         CCR_OP_SUB, CCR_OP_CMP: begin
            full = {1'b0, alu.opA} - {1'b0, alu.opB} - {16'h0000, alu.cin};
            nib16 = {1'b0, alu.opA[11:0]} - {1'b0, alu.opB[11:0]} - {12'h000, alu.cin};
            nib8 = {1'b0, alu.opA[3:0]} - {1'b0, alu.opB[3:0]} - {4'h0, alu.cin};
         end
         default: begin
         end
      endcase
      signA = alu.wide ? alu.opA[15] : alu.opA[7];
      signB = alu.wide ? alu.opB[15] : alu.opB[7];
      signR = alu.wide ? full[15] : full[7];
      case (alu.op)
         CCR_OP_ADD, CCR_OP_SUB, CCR_OP_CMP: begin
            alu.result = full[15:0];
            alu.resUpd = (alu.op != CCR_OP_CMP);
            alu.cy = alu.wide ? full[CCR_CY_POS_16] : full[CCR_CY_POS_8];
            alu.cyUpd = 1'b1;
            alu.ac = alu.wide ? nib16[CCR_AC_POS_16] : nib8[CCR_AC_POS_8];
            alu.acUpd = (alu.op != CCR_OP_CMP);
            // add: like signs giving the other sign; sub: unlike signs, sign lost
            if (alu.op == CCR_OP_ADD) begin
               alu.ov = (signA == signB) && (signR != signA);
            end else begin
               alu.ov = (signA != signB) && (signR != signA);
            end
            alu.ovUpd = (alu.op != CCR_OP_CMP);
         end
         CCR_OP_ROT: begin
            // rotate left through carry, byte wide
            alu.result = {8'h00, alu.opA[6:0], alu.cin};
            alu.resUpd = 1'b1;
            alu.cy = alu.opA[7];
            alu.cyUpd = 1'b1;
         end
         CCR_OP_MUL16: begin
            alu.ov = (alu.mdHi[7:0] != 8'h00);
            alu.ovUpd = 1'b1;
         end
         CCR_OP_MUL24: begin
            alu.ov = (alu.mdHi != 16'h0000);
            alu.ovUpd = 1'b1;
         end
         CCR_OP_DIV: begin
            alu.ov = (alu.divisor == 16'h0000);
            alu.ovUpd = 1'b1;
         end
         default: begin
         end
      endcase
   end
endmodule
`default_nettype wire

// >>> dv/ccr_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_checker
   import ccr_pkg::*;
#(
   parameter int unsigned PTR_COUNT = CCR_PTR_COUNT
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [15:0] busAddr,
   input wire logic busWe,
   input wire logic [7:0] busWdata,
   input wire logic ninthLoad,
   input wire logic ninthIn,
   input wire logic [15:0] ptrBase,
   input wire logic [5:0] ptrIndex,
   input wire logic [16:0] tblPtr,
   input wire logic [7:0] mainOperand,
   input wire logic [7:0] secondOperand,
   input wire logic [7:0] thirdOperand,
   input wire logic [7:0] statusWord,
   input wire logic [7:0] extAddrHigh,
   input wire logic [15:0] offsetAddr,
   input wire logic [17:0] romAddr,
   input wire logic [15:0] ptrAddrLo,
   input wire logic [15:0] ptrAddrHi,
   input wire logic stkWe,
   input wire logic stkRe,
   input wire logic [15:0] stkAddr,
   input wire logic [15:0] stackPointer,
   input wire logic retDone
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   logic stWr;
   assign stWr = busWe && busAddr == CCR_ADDR_STATUS;
   property p_par;
      statusWord[0] == ^mainOperand;
   endproperty
   a_par: assert property (p_par) else $error("parity bit wrong");
   property p_ext;
      extAddrHigh == secondOperand;
   endproperty
   a_ext: assert property (p_ext) else $error("ext address high wrong");
   // first edge after release still shows reset values, hence the guard
   property p_ptr;
      $past(arst_n) |-> ptrAddrLo == {9'h000, $past(ptrIndex), 1'b0}
         && ptrAddrHi == ptrAddrLo + 16'h0001 && ptrAddrLo < 16'(2 * PTR_COUNT);
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer address wrong");
   property p_off;
      $past(arst_n) |-> offsetAddr == $past(ptrBase)
         + {{8{$past(thirdOperand[7])}}, $past(thirdOperand)};
   endproperty
   a_off: assert property (p_off) else $error("offset address wrong");
   property p_rom;
      $past(arst_n) |-> romAddr == {statusWord[3], $past(tblPtr)};
   endproperty
   a_rom: assert property (p_rom) else $error("table address wrong");
   property p_push;
      stkWe |-> stkAddr == stackPointer;
   endproperty
   a_push: assert property (p_push) else $error("store not after increment");
   property p_ret;
      retDone |-> $past(stkRe, 2) && $past(stkRe, 3);
   endproperty
   a_ret: assert property (p_ret) else $error("return without two reads");
   property p_wr;
      busWe && busAddr == CCR_ADDR_SECOND |=> secondOperand == $past(busWdata);
   endproperty
   a_wr: assert property (p_wr) else $error("second register write lost");
   property p_user;
      !stWr |=> $stable(statusWord[5:4]);
   endproperty
   a_user: assert property (p_user) else $error("user bits moved");
   property p_nin;
      ninthLoad && !stWr |=> statusWord[1] == $past(ninthIn);
   endproperty
   a_nin: assert property (p_nin) else $error("ninth bit not loaded");
   c_ret: cover property (retDone);
   c_call: cover property (stkWe ##1 stkWe);
   c_ov: cover property (statusWord[2]);
endmodule
bind cpu_core_register_set ccr_checker #(.PTR_COUNT(PTR_COUNT)) i_chk (.ref_clk, .arst_n,
   .busAddr, .busWe, .busWdata, .ninthLoad, .ninthIn, .ptrBase, .ptrIndex, .tblPtr,
   .mainOperand, .secondOperand, .thirdOperand, .statusWord, .extAddrHigh, .offsetAddr,
   .romAddr, .ptrAddrLo, .ptrAddrHi, .stkWe, .stkRe, .stkAddr, .stackPointer, .retDone);
`default_nettype wire

// >>> dv/ccr_stack_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_stack_ram_model (
   input wire logic ref_clk,
   input wire logic stkWe,
   input wire logic stkRe,
   input wire logic [15:0] stkAddr,
   input wire logic [8:0] stkWrData,
   output logic [8:0] stkRdData
);
   logic [8:0] mem [16];
   logic [8:0] rdR = 9'h000;
   // data valid one cycle after a read only; toggles otherwise so stale use shows
   always_ff @(posedge ref_clk) begin
      if (stkWe) begin
         mem[stkAddr[3:0]] <= stkWrData;
      end
      if (stkRe) begin
         rdR <= mem[stkAddr[3:0]];
      end else begin
         rdR <= ~rdR;
      end
   end
   assign stkRdData = rdR;
endmodule
`default_nettype wire

// >>> dv/cpu_core_register_set_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_register_set_bench;
   import ccr_pkg::*;
   logic ref_clk, arst_n, busWe, busRe, ldA, ldB, ldC, aluGo, aluWide, aluUseCarry;
   logic ninthLoad, ninthIn, callReq, callBank, retReq, pushReq, popReq;
   logic stkWe, stkRe, retBank, retDone;
   logic [15:0] busAddr, aluOperand, mdHigh, divisor, ptrBase;
   logic [15:0] stackPointer, offsetAddr, ptrAddrLo, ptrAddrHi, stkAddr;
   logic [7:0] busWdata, ldData, busRdata, mainOperand, secondOperand;
   logic [7:0] thirdOperand, statusWord, extAddrHigh;
   logic [23:0] mdResult;
   logic [5:0] ptrIndex;
   logic [16:0] tblPtr, callAddr, retAddr;
   logic [8:0] pushData, stkRdData, stkWrData;
   logic [17:0] romAddr;
   ccr_op_t aluOp;
   int err_count = 0;
   int tests_run = 0;
   int i;
   logic [15:0] addrs [6] = '{CCR_ADDR_MAIN, CCR_ADDR_SECOND, CCR_ADDR_THIRD,
      CCR_ADDR_STATUS, CCR_ADDR_SP_LO, CCR_ADDR_SP_HI};
   logic [7:0] vals [6] = '{8'h07, 8'hA5, 8'h3C, 8'h30, 8'h81, 8'h7E};
   ccr_op_t mop [5] = '{CCR_OP_MUL16, CCR_OP_MUL16, CCR_OP_MUL24, CCR_OP_DIV, CCR_OP_DIV};
   logic [15:0] mhi [5] = '{16'h0001, 16'h0100, 16'h0100, 16'h0000, 16'h0000};
   logic [15:0] mdv [5] = '{16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0001};
   logic mov [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

   cpu_core_register_set i_dut (.ref_clk, .arst_n, .busAddr, .busWe, .busRe, .busWdata,
      .busRdata, .ldA, .ldB, .ldC, .ldData, .aluGo, .aluOp, .aluWide, .aluUseCarry,
      .aluOperand, .mdResult, .mdHigh, .divisor, .ninthLoad, .ninthIn, .ptrBase, .ptrIndex,
      .tblPtr, .callReq, .callAddr, .callBank, .retReq, .pushReq, .pushData, .popReq,
      .stkRdData, .mainOperand, .secondOperand, .thirdOperand, .statusWord, .stackPointer,
      .extAddrHigh, .offsetAddr, .romAddr, .ptrAddrLo, .ptrAddrHi, .stkWe, .stkRe, .stkAddr,
      .stkWrData, .retAddr, .retBank, .retDone);
   ccr_stack_ram_model i_ram (.ref_clk, .stkWe, .stkRe, .stkAddr, .stkWrData, .stkRdData);

   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step;
      @(negedge ref_clk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      busAddr = a;
      busWdata = d;
      busWe = 1'b1;
      step();
      busWe = 1'b0;
      step();
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      busAddr = a;
      busRe = 1'b1;
      step();
      busRe = 1'b0;
      chk(busRdata, e);
      step();
   endtask
   task automatic alu(input ccr_op_t op, input logic w, input logic [15:0] b);
      aluOp = op;
      aluWide = w;
      aluOperand = b;
      aluGo = 1'b1;
      step();
      aluGo = 1'b0;
      step();
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // about 112 cycles are needed; the 2000-cycle limit is ample
   initial begin
      #100000;
      err_count++;
      give_verdict();
   end

   initial begin
      {arst_n, busWe, busRe, ldA, ldB, ldC, aluGo, aluWide, aluUseCarry, ninthLoad, ninthIn,
         callReq, callBank, retReq, pushReq, popReq, busAddr, aluOperand, mdHigh, divisor,
         ptrBase, busWdata, ldData, mdResult, ptrIndex, tblPtr, callAddr, pushData} = '0;
      aluOp = CCR_OP_NONE;
      repeat (16) step();
      arst_n = 1'b1;
      step();
      foreach (addrs[k]) rd(addrs[k], CCR_RST_BYTE);
      rd(16'hFE03, CCR_RD_UNMAPPED);
      foreach (addrs[k]) wr(addrs[k], vals[k]);
      // status readback: parity comes from main (07 is odd)
      foreach (addrs[k]) rd(addrs[k], (k == 3) ? 8'h31 : vals[k]);
      chk(stackPointer, 16'h7E81);
      wr(CCR_ADDR_STATUS, 8'h00);
      wr(CCR_ADDR_MAIN, 8'h7F);
      alu(CCR_OP_ADD, 1'b0, 16'h0001);
      chk({mainOperand, statusWord}, 16'h8045);
      wr(CCR_ADDR_MAIN, 8'h00);
      alu(CCR_OP_SUB, 1'b0, 16'h0001);
      chk({mainOperand, statusWord}, 16'hFFC0);
      wr(CCR_ADDR_SECOND, 8'h0F);
      wr(CCR_ADDR_MAIN, 8'hFF);
      alu(CCR_OP_ADD, 1'b1, 16'h0001);
      chk({secondOperand, mainOperand, statusWord}, 24'h100040);
      alu(CCR_OP_CMP, 1'b0, 16'h0001);
      chk({mainOperand, statusWord}, 16'h00C0);
      aluUseCarry = 1'b1;
      alu(CCR_OP_ROT, 1'b0, 16'h0000);
      aluUseCarry = 1'b0;
      chk({mainOperand, statusWord}, 16'h0141);
      mdResult = 24'h332211;
      for (i = 0; i < 5; i++) begin
         mdHigh = mhi[i];
         divisor = mdv[i];
         alu(mop[i], 1'b0, 16'h0000);
         chk(statusWord[2], mov[i]);
         chk({thirdOperand, secondOperand, mainOperand}, mdResult);
      end
      ninthIn = 1'b1;
      ninthLoad = 1'b1;
      step();
      ninthLoad = 1'b0;
      chk(statusWord[1], 1'b1);
      wr(CCR_ADDR_STATUS, 8'h38);
      alu(CCR_OP_ADD, 1'b0, 16'h0000);
      chk(statusWord, 8'h38);
      tblPtr = 17'h1FFFF;
      step();
      chk(romAddr, 18'h3FFFF);
      wr(CCR_ADDR_STATUS, 8'h00);
      chk(romAddr, 18'h1FFFF);
      ldData = 8'h5A;
      ldB = 1'b1;
      step();
      ldB = 1'b0;
      chk({extAddrHigh, secondOperand}, 16'h5A5A);
      ldData = 8'hFF;
      ldC = 1'b1;
      ptrBase = 16'hFE02;
      ptrIndex = 6'd63;
      step();
      ldC = 1'b0;
      step();
      chk(offsetAddr, 16'hFE01);
      chk({ptrAddrHi, ptrAddrLo}, 32'h007F007E);
      ldData = 8'h01;
      ldA = 1'b1;
      step();
      ldA = 1'b0;
      chk(statusWord[0], 1'b1);
      wr(CCR_ADDR_SP_LO, 8'h00);
      wr(CCR_ADDR_SP_HI, 8'h00);
      pushData = 9'h155;
      pushReq = 1'b1;
      step();
      pushReq = 1'b0;
      chk({stkWe, stkAddr, stkWrData, stackPointer}, {1'b1, 16'h0001, 9'h155, 16'h0001});
      callAddr = 17'h1ABCD;
      callBank = 1'b1;
      callReq = 1'b1;
      step();
      callReq = 1'b0;
      chk({stkWe, stkAddr, stkWrData}, {1'b1, 16'h0002, 9'h1CD});
      step();
      chk({stkWe, stkAddr, stkWrData}, {1'b1, 16'h0003, 9'h1AB});
      chk(stackPointer, 16'h0003);
      step();
      retReq = 1'b1;
      step();
      retReq = 1'b0;
      for (i = 0; i < 8 && retDone !== 1'b1; i++) step();
      chk({retDone, retBank, retAddr}, {1'b1, 1'b1, 17'h1ABCD});
      chk(stackPointer, 16'h0001);
      step();
      popReq = 1'b1;
      step();
      popReq = 1'b0;
      chk({stkRe, stkAddr}, {1'b1, 16'h0001});
      step();
      chk(stackPointer, 16'h0000);
      give_verdict();
   end
endmodule
`default_nettype wire
